/* File: src/soc_pkg.sv */
`default_nettype none
package soc_pkg;
    // geometry, fixed
    localparam int N_BEAMS = 32;
    localparam int N_OUT = 2;
    localparam int N_ZONE = 4;
    localparam int N_DIN = 2;
    localparam int DIV_W = 24;
    localparam int TMR_W = 9;

    // timing: 1 ms base for the minimum pulse width
    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_PERIOD_NS = 1000000;
    localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] OFS_OUT_CFG0 = 8'h00;
    localparam logic [7:0] OFS_OUT_CFG1 = 8'h04;
    localparam logic [7:0] OFS_ZONE0 = 8'h08;
    localparam logic [7:0] OFS_ZONE1 = 8'h0C;
    localparam logic [7:0] OFS_ZONE2 = 8'h10;
    localparam logic [7:0] OFS_ZONE3 = 8'h14;
    localparam logic [7:0] OFS_BLANK = 8'h18;
    localparam logic [7:0] OFS_DIN_ASSIGN = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_BEAMS = 8'h24;
    localparam logic [7:0] OFS_VALUE0 = 8'h28;
    localparam logic [7:0] OFS_VALUE1 = 8'h2C;

    // output config field positions
    localparam int F_FUNC = 0;
    localparam int F_ZONE = 3;
    localparam int F_CMP = 5;
    localparam int F_INV = 7;
    localparam int F_GATE_EN = 8;
    localparam int F_GATE_SEL = 9;
    localparam int F_GATE_POL = 10;
    localparam int F_THR = 16;
    localparam int F_MIN_MS = 24;
    // zone register field positions
    localparam int F_ZFIRST = 0;
    localparam int F_ZLAST = 8;

    // reset values
    localparam logic [31:0] OUT_CFG_RST = 32'h0000_0000;
    localparam logic [5:0] ZFIRST_RST = 6'h01;
    localparam logic [5:0] ZLAST_RST = 6'h20;
    localparam logic [31:0] BLANK_RST = 32'h0000_0000;

    // beam function select
    localparam logic [2:0] FN_BLOCKED_COUNT = 3'h0;
    localparam logic [2:0] FN_LAST_BLOCKED = 3'h1;
    localparam logic [2:0] FN_FIRST_BLOCKED = 3'h2;
    localparam logic [2:0] FN_CONSEC_BLOCKED = 3'h3;
    localparam logic [2:0] FN_CONSEC_COUNT = 3'h4;
    // comparison against threshold
    localparam logic [1:0] CMP_GE = 2'h0;
    localparam logic [1:0] CMP_LE = 2'h1;
    localparam logic [1:0] CMP_EQ = 2'h2;
    localparam logic [1:0] CMP_NZ = 2'h3;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } soc_bus_req_t;

    typedef struct packed {
        logic [N_OUT-1:0][31:0] out_cfg;
        logic [N_ZONE-1:0][5:0] zfirst;
        logic [N_ZONE-1:0][5:0] zlast;
        logic [N_BEAMS-1:0] blank;
        logic [N_DIN-1:0] din_other;
        logic [N_DIN-1:0] s1;
        logic [N_DIN-1:0] s2;
        logic [N_DIN-1:0] s3;
        logic [N_DIN-1:0] din;
        logic [DIV_W-1:0] div;
        logic tick;
        logic [N_OUT-1:0] gated;
        logic [N_OUT-1:0] outq;
        logic [N_OUT-1:0] pend;
        logic [N_OUT-1:0][TMR_W-1:0] timer;
        logic [31:0] rdata;
    } soc_state_t;
endpackage
`default_nettype wire

/* File: src/soc_conditioner.sv */
// Function
// - each output can invert its level relative to the beam-function result.
// - each output holds a minimum pulse width in milliseconds.
// - an active pulse shorter than the minimum width is held active until it is reached.
// - a pulse already at least the minimum width passes with its length unchanged; the code may lengthen one under the minimum plus 1 ms.
// - the gap between two stretched pulses is also held for at least the minimum width.
// - with gating on, an output changes status only while the selected input is active.
// - the gating input can be set high active or low active.
// - gating takes effect only if the chosen input is not assigned to another function.
// - beams can be split into up to four zones numbered one to four.
// - each zone is bounded by a first-beam and a last-beam number.
// - each output selects its own function and zone and evaluates only that zone.
// - each zone offers count, last, first, consecutive and consecutive-count functions.
// - the count function gives the blocked beams in the zone, zero if none.
// - blanked beams are ignored by every function.
//
// Added by the designer: the register offsets and strobed register access.
`default_nettype none
module soc_conditioner #(
    parameter int unsigned P_MS_CYCLES = soc_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // register port
    input wire soc_pkg::soc_bus_req_t i_bus,
    output logic [31:0] o_rdata,
    // beam states from the scan logic, same clock
    input wire logic [soc_pkg::N_BEAMS-1:0] i_beam_blocked,
    // digital input pins, asynchronous
    input wire logic [soc_pkg::N_DIN-1:0] i_din,
    // switching outputs
    output logic [soc_pkg::N_OUT-1:0] o_switching_output
);
    import soc_pkg::*;

    soc_state_t st_r;
    soc_state_t st_nxt;
    logic [N_OUT-1:0][5:0] value;
    logic [N_OUT-1:0] hit;

    // zone-restricted beam functions; blanked beams neither extend nor break a run
    function automatic logic [5:0] beam_eval(input logic [N_BEAMS-1:0] blk,
            input logic [N_BEAMS-1:0] bl, input logic [5:0] lo, input logic [5:0] hi,
            input logic [2:0] fs);
        logic [5:0] cnt;
        logic [5:0] first;
        logic [5:0] last;
        logic [5:0] run;
        logic [5:0] best;
        logic [5:0] groups;
        logic prev;
        logic [5:0] idx;
        logic [5:0] res;
        cnt = 6'h00;
        first = 6'h00;
        last = 6'h00;
        run = 6'h00;
        best = 6'h00;
        groups = 6'h00;
        prev = 1'b0;
        res = 6'h00;
        for (int i = 0; i < N_BEAMS; i++) begin
            idx = 6'(i + 1);
            if (idx >= lo && idx <= hi && !bl[i]) begin
                if (blk[i]) begin
                    cnt = cnt + 6'h01;
                    if (first == 6'h00) begin
                        first = idx;
                    end
                    last = idx;
                    if (!prev) begin
                        groups = groups + 6'h01;
                    end
                    run = run + 6'h01;
                    if (run > best) begin
                        best = run;
                    end
                    prev = 1'b1;
                end else begin
                    run = 6'h00;
                    prev = 1'b0;
                end
            end
        end
        case (fs)
            FN_BLOCKED_COUNT: res = cnt;
            FN_LAST_BLOCKED: res = last;
            FN_FIRST_BLOCKED: res = first;
            FN_CONSEC_BLOCKED: res = best;
            FN_CONSEC_COUNT: res = groups;
            default: res = 6'h00;
        endcase
        return res;
    endfunction

    // per-output evaluation over its own zone
    for (genvar k = 0; k < N_OUT; k++) begin : g_eval
        logic [31:0] cfg;
        logic [1:0] zsel;
        logic [5:0] thr;
        assign cfg = st_r.out_cfg[k];
        assign zsel = cfg[F_ZONE +: 2];
        assign thr = cfg[F_THR +: 6];
        assign value[k] = beam_eval(i_beam_blocked, st_r.blank, st_r.zfirst[zsel],
            st_r.zlast[zsel], cfg[F_FUNC +: 3]);
        always_comb begin
            case (cfg[F_CMP +: 2])
                CMP_GE: hit[k] = value[k] >= thr;
                CMP_LE: hit[k] = value[k] <= thr;
                CMP_EQ: hit[k] = value[k] == thr;
                default: hit[k] = value[k] != 6'h00;
            endcase
        end
    end

    // next-state logic for registers, sync, timers and read data
    always_comb begin
        logic [31:0] c;
        logic sel;
        logic gate_ok;
        logic pre;
        logic [TMR_W-1:0] min_ms;
        c = 32'h0000_0000;
        sel = 1'b0;
        gate_ok = 1'b0;
        pre = 1'b0;
        min_ms = '0;
        st_nxt = st_r;

        // pins: three stages, accept a change once the last two agree
        st_nxt.s1 = i_din;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int d = 0; d < N_DIN; d++) begin
            if (st_r.s2[d] == st_r.s3[d]) begin
                st_nxt.din[d] = st_r.s3[d];
            end
        end

        // millisecond enable; shared so all outputs see the same base
        st_nxt.tick = 1'b0;
        if (st_r.div >= DIV_W'(P_MS_CYCLES - 1)) begin
            st_nxt.div = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.div = st_r.div + DIV_W'(1);
        end

        // register writes
        if (i_bus.wr) begin
            case (i_bus.addr)
                OFS_OUT_CFG0: st_nxt.out_cfg[0] = i_bus.wdata;
                OFS_OUT_CFG1: st_nxt.out_cfg[1] = i_bus.wdata;
                OFS_ZONE0, OFS_ZONE1, OFS_ZONE2, OFS_ZONE3: begin
                    st_nxt.zfirst[i_bus.addr[3:2] - 2'h2] = i_bus.wdata[F_ZFIRST +: 6];
                    st_nxt.zlast[i_bus.addr[3:2] - 2'h2] = i_bus.wdata[F_ZLAST +: 6];
                end
                OFS_BLANK: st_nxt.blank = i_bus.wdata;
                OFS_DIN_ASSIGN: st_nxt.din_other = i_bus.wdata[N_DIN-1:0];
                default: ;
            endcase
        end

        // per output: gate, invert, stretch
        for (int k = 0; k < N_OUT; k++) begin
            c = st_r.out_cfg[k];
            sel = c[F_GATE_SEL];
            // input already used elsewhere leaves the output ungated
            gate_ok = !c[F_GATE_EN] || st_r.din_other[sel]
                || (st_r.din[sel] == c[F_GATE_POL]);
            if (gate_ok) begin
                st_nxt.gated[k] = hit[k];
            end
            pre = st_r.gated[k] ^ c[F_INV];
            min_ms = {1'b0, c[F_MIN_MS +: 8]};
            if (st_r.timer[k] != '0) begin
                // change blocked while the width timer runs, but remembered, so a
                // short pulse inside a held gap is not lost
                if (pre != st_r.outq[k]) begin
                    st_nxt.pend[k] = 1'b1;
                end
                if (st_r.tick) begin
                    st_nxt.timer[k] = st_r.timer[k] - TMR_W'(1);
                end
            end else if (pre != st_r.outq[k] || st_r.pend[k]) begin
                // one extra tick since the phase of the ms base is unknown
                st_nxt.outq[k] = ~st_r.outq[k];
                st_nxt.pend[k] = 1'b0;
                st_nxt.timer[k] = (min_ms == '0) ? '0 : min_ms + TMR_W'(1);
            end
        end

        // read data valid only in the cycle after the read strobe
        st_nxt.rdata = 32'h0000_0000;
        if (i_bus.rd) begin
            case (i_bus.addr)
                OFS_OUT_CFG0: st_nxt.rdata = st_r.out_cfg[0];
                OFS_OUT_CFG1: st_nxt.rdata = st_r.out_cfg[1];
                OFS_ZONE0, OFS_ZONE1, OFS_ZONE2, OFS_ZONE3: begin
                    st_nxt.rdata[F_ZFIRST +: 6] = st_r.zfirst[i_bus.addr[3:2] - 2'h2];
                    st_nxt.rdata[F_ZLAST +: 6] = st_r.zlast[i_bus.addr[3:2] - 2'h2];
                end
                OFS_BLANK: st_nxt.rdata = st_r.blank;
                OFS_DIN_ASSIGN: st_nxt.rdata[N_DIN-1:0] = st_r.din_other;
                OFS_STATUS: st_nxt.rdata[5:0] = {st_r.din, st_r.gated, st_r.outq};
                OFS_BEAMS: st_nxt.rdata = i_beam_blocked;
                OFS_VALUE0: st_nxt.rdata[5:0] = value[0];
                OFS_VALUE1: st_nxt.rdata[5:0] = value[1];
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0;
            st_r.out_cfg <= {N_OUT{OUT_CFG_RST}};
            st_r.zfirst <= {N_ZONE{ZFIRST_RST}};
            st_r.zlast <= {N_ZONE{ZLAST_RST}};
            st_r.blank <= BLANK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata = st_r.rdata;
    assign o_switching_output = st_r.outq;
endmodule
`default_nettype wire

/* File: tb/soc_conditioner_sva.sv */
`default_nettype none
module soc_conditioner_sva
    import soc_pkg::*;
#(
    parameter int unsigned P_MS_CYCLES = 10
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // watched ports
    input wire soc_pkg::soc_bus_req_t i_bus,
    input wire logic [31:0] o_rdata,
    input wire logic [soc_pkg::N_BEAMS-1:0] i_beam_blocked,
    input wire logic [soc_pkg::N_DIN-1:0] i_din,
    input wire logic [soc_pkg::N_OUT-1:0] o_switching_output
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic [N_OUT-1:0] prev_r;
    logic [N_OUT-1:0][31:0] cnt_r;
    logic [N_OUT-1:0][7:0] mw_r;
    logic [N_OUT-1:0][7:0] lm_r;
    // phase length per output, with the width that was in force when it began
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_r <= '0;
            cnt_r <= '0;
            mw_r <= '0;
            lm_r <= '0;
        end else begin
            prev_r <= o_switching_output;
            for (int k = 0; k < N_OUT; k++) begin
                if (i_bus.wr && i_bus.addr == OFS_OUT_CFG0 + 8'(4 * k)) begin
                    mw_r[k] <= i_bus.wdata[F_MIN_MS+:8];
                end
                if (o_switching_output[k] != prev_r[k]) begin
                    cnt_r[k] <= 32'h1;
                    lm_r[k] <= mw_r[k];
                end else begin
                    cnt_r[k] <= cnt_r[k] + 32'h1;
                end
            end
        end
    end
    rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
        else $error("read data without a read");
    beams_read_a: assert property (i_bus.rd && i_bus.addr == OFS_BEAMS
        |=> o_rdata == $past(i_beam_blocked)) else $error("beam image wrong");
    status_out_a: assert property (i_bus.rd && i_bus.addr == OFS_STATUS
        |=> o_rdata[1:0] == $past(o_switching_output)) else $error("status outputs wrong");
    unmapped_read_a: assert property (i_bus.rd && i_bus.addr > OFS_VALUE1
        |=> o_rdata == 32'h0) else $error("unmapped read not zero");
    zero_count_a: assert property (i_bus.rd && i_bus.addr == OFS_VALUE0
        && i_beam_blocked == '0 && $past(i_beam_blocked) == '0
        |=> o_rdata[5:0] == 6'h00) else $error("value not zero with no beam");
    din_sync_a: assert property ($stable(i_din)[*6] ##0
        (i_bus.rd && i_bus.addr == OFS_STATUS) |=> o_rdata[5:4] == $past(i_din))
        else $error("synced inputs wrong");
    width_out0_a: assert property (o_switching_output[0] != prev_r[0]
        |-> cnt_r[0] >= 32'(lm_r[0]) * P_MS_CYCLES) else $error("output 0 phase too short");
    width_out1_a: assert property (o_switching_output[1] != prev_r[1]
        |-> cnt_r[1] >= 32'(lm_r[1]) * P_MS_CYCLES) else $error("output 1 phase too short");
endmodule
bind soc_conditioner soc_conditioner_sva #(.P_MS_CYCLES(P_MS_CYCLES)) chk_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_beam_blocked(i_beam_blocked), .i_din(i_din), .o_switching_output(o_switching_output));
`default_nettype wire

/* File: tb/soc_ctrl_model.sv */
`default_nettype none
module soc_ctrl_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // switching output as the control sees it
    input wire logic i_level,
    // length of the last whole high and low phase
    output logic [31:0] o_hi_len,
    output logic [31:0] o_lo_len
);
    timeunit 1ns;
    timeprecision 100ps;
    logic prev_r;
    logic [31:0] run_r;
    // a slow control only trusts whole phases, so their lengths are kept
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_r <= 1'b0;
            run_r <= 32'h0;
            o_hi_len <= 32'h0;
            o_lo_len <= 32'h0;
        end else begin
            prev_r <= i_level;
            run_r <= (i_level != prev_r) ? 32'h1 : run_r + 32'h1;
            if (i_level != prev_r && prev_r) o_hi_len <= run_r;
            if (i_level != prev_r && !prev_r) o_lo_len <= run_r;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb_switching_output_conditioner.sv */
`default_nettype none
module tb_switching_output_conditioner import soc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int P = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    soc_bus_req_t bus = '0;
    logic [31:0] rdata, rv, hi_len, lo_len;
    logic [31:0] seed = 32'h258B19FF;
    logic [N_BEAMS-1:0] beams = '0;
    logic [N_DIN-1:0] din = 2'h1;
    logic [N_OUT-1:0] sw;
    int n_fail = 0;
    int total_checks = 0;
    always #2.5 clk = ~clk;
    soc_conditioner #(.P_MS_CYCLES(P)) dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_bus(bus),
        .o_rdata(rdata), .i_beam_blocked(beams), .i_din(din), .o_switching_output(sw));
    soc_ctrl_model ctrl_u (.i_clk(clk), .i_rst_n(rst_n), .i_level(sw[0]),
        .o_hi_len(hi_len), .o_lo_len(lo_len));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected zone value: blanked beams are skipped and never break a run
    function automatic logic [31:0] ev(logic [31:0] b, bl, logic [5:0] lo, hi, logic [2:0] f);
        int c = 0, l = 0, fi = 0, run = 0, best = 0, runs = 0;
        for (int i = 1; i <= 32; i++) begin
            if (i >= lo && i <= hi && !bl[i-1]) begin
                if (b[i-1]) begin
                    c++;
                    l = i;
                    if (fi == 0) fi = i;
                    run++;
                    if (run == 1) runs++;
                    if (run > best) best = run;
                end else run = 0;
            end
        end
        case (f)
            3'h0: return c;
            3'h1: return l;
            3'h2: return fi;
            3'h3: return best;
            default: return runs;
        endcase
    endfunction
    // expected threshold result for one compare mode
    function automatic logic eh(logic [31:0] v, logic [1:0] cm, logic [5:0] th);
        case (cm)
            CMP_GE: return v >= 32'(th);
            CMP_LE: return v <= 32'(th);
            CMP_EQ: return v == 32'(th);
            default: return v != 32'h0;
        endcase
    endfunction
    function automatic logic [31:0] mk(logic [2:0] f, logic [1:0] z, logic inv, logic [2:0] g,
        logic [7:0] mw);
        return 32'(f) << F_FUNC | 32'(z) << F_ZONE | 32'(CMP_NZ) << F_CMP | 32'(inv) << F_INV
            | 32'(g) << F_GATE_EN | 32'(mw) << F_MIN_MS;
    endfunction
    // compares
    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkr(input logic [31:0] got, lo, hi);
        total_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    // register port cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk) bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk) bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pulse(input int n);
        @(posedge clk) beams <= 32'h1;
        w(n);
        beams <= '0;
    endtask
    task automatic conclude();
        $display("checks=%0d errors=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog, well above the length of the sequence
    initial begin
        w(20000);
        n_fail++;
        conclude();
    end
    initial begin
        logic [31:0] b, bl;
        logic [5:0] lo, hi;
        logic [2:0] fn;
        logic [1:0] z, cm;
        logic [5:0] th;
        w(3);
        chk(32'(sw), 32'h0);
        rst_n <= 1'b1;
        rd(OFS_ZONE0, rv);
        chk(rv, 32'h0000_2001);
        for (int it = 0; it < 16; it++) begin
            {b, bl, z, fn} = {rnd(), rnd() & rnd(), 2'(rnd()), 3'(rnd() % 5)};
            // hand-written corners first: nothing blocked, then everything blocked
            if (it < 2) b = (it == 0) ? 32'h0 : 32'hFFFF_FFFF;
            {cm, th} = {2'(rnd()), 6'(rnd())};
            {lo, hi} = {6'(1 + rnd() % 32), 6'(1 + rnd() % 32)};
            wr(OFS_ZONE0 + 8'(4 * z), 32'(hi) << F_ZLAST | 32'(lo));
            wr(OFS_BLANK, bl);
            wr(OFS_OUT_CFG0, mk(fn, z, 1'b0, 3'h0, 8'h0) & ~(32'h3 << F_CMP)
                | 32'(cm) << F_CMP | 32'(th) << F_THR);
            @(posedge clk) beams <= b;
            rd(OFS_VALUE0, rv);
            chk({26'h0, rv[5:0]}, ev(b, bl, lo, hi, fn));
            rd(OFS_STATUS, rv);
            rv = {30'h0, rv[2], rv[0]};
            chk(rv, eh(ev(b, bl, lo, hi, fn), cm, th) ? 32'h3 : 32'h0);
        end
        rd(OFS_BEAMS, rv);
        chk(rv, b);
        wr(OFS_ZONE0, 32'h0000_2001);
        wr(OFS_BLANK, 32'h0);
        wr(OFS_OUT_CFG0, mk(3'h0, 2'h0, 1'b0, 3'h0, 8'h2));
        wr(OFS_OUT_CFG1, mk(3'h0, 2'h0, 1'b0, 3'b101, 8'h0));
        @(posedge clk) beams <= '0;
        w(40);
        pulse(3);
        w(80);
        chkr(hi_len, 2 * P, 3 * P + 1);
        pulse(60);
        w(80);
        chk(hi_len, 32'd60);
        // second pulse starts after the first stretched one ended, inside the held gap
        pulse(2);
        w(30);
        pulse(2);
        w(100);
        chkr(lo_len, 2 * P, 3 * P + 1);
        chkr(hi_len, 2 * P, 3 * P + 1);
        // the gate input needs its synchroniser delay before the beams move
        @(posedge clk) din <= 2'h0;
        w(6);
        beams <= 32'h1;
        w(10);
        chk(32'(sw[1]), 32'h0);
        din <= 2'h1;
        w(8);
        chk(32'(sw[1]), 32'h1);
        din <= 2'h0;
        w(6);
        beams <= '0;
        w(8);
        chk(32'(sw[1]), 32'h1);
        wr(OFS_OUT_CFG1, mk(3'h0, 2'h0, 1'b0, 3'b001, 8'h0));
        w(8);
        chk(32'(sw[1]), 32'h0);
        din <= 2'h1;
        w(6);
        beams <= 32'h1;
        w(8);
        chk(32'(sw[1]), 32'h0);
        wr(OFS_DIN_ASSIGN, 32'h1);
        w(6);
        chk(32'(sw[1]), 32'h1);
        wr(OFS_OUT_CFG0, mk(3'h0, 2'h0, 1'b1, 3'h0, 8'h0));
        @(posedge clk) beams <= '0;
        w(40);
        chk(32'(sw[0]), 32'h1);
        rd(8'hFC, rv);
        chk(rv, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
